// [dpc_consts.vh]
// Register offsets, field positions, reset values and sequencer states
`ifndef DPC_CONSTS_VH
`define DPC_CONSTS_VH
`define DPC_ADDR_W 4
`define DPC_OFF_CYL 4'h0
`define DPC_OFF_HEAD 4'h1
`define DPC_OFF_SECT 4'h2
`define DPC_OFF_FUNC 4'h3
`define DPC_OFF_UNIT 4'h4
`define DPC_OFF_CTRL 4'h5
`define DPC_OFF_STAT 4'h6
`define DPC_OFF_ATTN 4'h7
`define DPC_OFF_WCNT 4'h8
`define DPC_OFF_SW 4'h9
// Control register bits
`define DPC_CTRL_GO 0
`define DPC_CTRL_CEMASK 1
`define DPC_CTRL_ATMASK 2
`define DPC_CTRL_CLRERR 3
// Status register bits
`define DPC_ST_BUSY 0
`define DPC_ST_DONE 1
`define DPC_ST_ATTN 2
`define DPC_ST_ERR 3
`define DPC_ST_DISK 4
`define DPC_ST_BRK 5
`define DPC_ST_WCOV 6
`define DPC_ST_FMT 7
`define DPC_ST_NORMAL_STATUS 8
`define DPC_ST_LOCK 9
`define DPC_ST_SELECTED_UNIT_LOCKOUT_FLAG 10
`define DPC_ST_WPERR 11
`define DPC_ST_DRVERR 12
// Function codes
`define DPC_FN_WRITE 3'h1
`define DPC_FN_WRALL 3'h3
`define DPC_FN_FORMAT 3'h5
// Reset values
`define DPC_RST_CTRL 3'h0
// Sequencer states
`define DPC_S_IDLE 2'h0
`define DPC_S_SETUP 2'h1
`define DPC_S_XFER 2'h2
`define DPC_S_DONE 2'h3
`endif

// [dpc_lockout_cmp.v]
// Write lockout comparator for unit and cylinder
`timescale 1ns/1ps
module dpc_lockout_cmp #(
    parameter CYL_W = 8
) (
    input wire lockEnable,
    input wire [2:0] driveSelect,
    input wire [CYL_W-1:0] cylinderTarget,
    input wire [2:0] lockoutUnit,
    input wire [2:0] lockoutCylinder,
    output wire lockHit
);
    // Cylinders zero through the switch value are protected inclusively
    assign lockHit = lockEnable && (driveSelect == lockoutUnit) &&
        (cylinderTarget <= {{(CYL_W-3){1'b0}}, lockoutCylinder});
endmodule

// [dpc_word_counter.v]
// Transfer word counter with overflow pulse
`timescale 1ns/1ps
module dpc_word_counter #(
    parameter WC_W = 16
) (
    input wire sys_clk,
    input wire nrst,
    input wire load,
    input wire [WC_W-1:0] loadValue,
    input wire step,
    output reg [WC_W-1:0] remaining_reg,
    output wire lastWord
);
    // Last word when one transfer remains and it is being taken
    assign lastWord = step && (remaining_reg == {{(WC_W-1){1'b0}}, 1'b1});

    // Counts down per word and holds at zero; a zero load means no words
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            remaining_reg <= {WC_W{1'b0}};
        end else if (load) begin
            remaining_reg <= loadValue;
        end else if (step && remaining_reg != {WC_W{1'b0}}) begin
            remaining_reg <= remaining_reg - {{(WC_W-1){1'b0}}, 1'b1};
        end
    end
endmodule

// [dpc_disk_control.v]
// Disk pack controller: registers, sequencer, status and lockout
`timescale 1ns/1ps
`include "dpc_consts.vh"
// Operation
// - Eight-bit cylinder target register loaded by software.
// - Five-bit head target register loaded by software.
// - Four-bit sector target register loaded by software.
// - Three-bit function code selects one of eight functions.
// - Three-bit drive select names the selected unit.
// - Busy is high in every sequencer state except idle.
// - Writing the start bit launches the current function.
// - Completion/error mask withholds done and error from interrupts.
// - Attention mask withholds all unit attention from interrupts.
// - Summary disk flag is OR of done, attention and error.
// - Done flag rises when a function completes.
// - Attention is OR of eight unit bits set on seek completion.
// - Error flag is OR of every individual error condition.
// - Break request asks memory for each data transfer cycle.
// - Word count overflow rises when the last word of a nonzero count is transferred.
// - Format switch selects write-all formatting, otherwise normal.
// - Format and normal status bits follow the format switch.
// - Lockout enable write-protects the chosen unit's cylinder range.
// - Lockout status bit follows the lockout enable input.
// - Three-bit lockout unit picks the protected drive.
// - Lockout cylinder protects cylinders zero up to its value.
// - Selected-unit lockout when enabled, unit matches, cylinder at most.
// - Writes to read-only or locked cylinders are blocked and flagged.
module dpc_disk_control #(
    parameter WC_W = 16,
    parameter DATA_W = 18
) (
    input wire sys_clk,
    input wire nrst,
    input wire [3:0] regAddr,
    input wire [DATA_W-1:0] regWdata,
    input wire regWrite,
    input wire regRead,
    output reg [DATA_W-1:0] regRdata_reg,
    input wire formatSwitch,
    input wire lockoutEnable,
    input wire [2:0] lockoutUnit,
    input wire [2:0] lockoutCylinder,
    input wire [7:0] seekComplete,
    input wire unitReadOnly,
    input wire driveFault,
    input wire memoryBreakGrant,
    input wire driveWordStrobe,
    output reg memoryBreakRequest_reg,
    output reg writeRequest_reg,
    output reg writeAllMode_reg,
    output reg programInterrupt_reg,
    output reg priorityInterrupt_reg,
    output reg busy_reg,
    output reg [2:0] activeFunction_reg,
    output reg [2:0] activeUnit_reg
);
    reg [7:0] cylinderTarget_reg;
    reg [4:0] headTarget_reg;
    reg [3:0] sectorTarget_reg;
    reg [2:0] functionCode_reg;
    reg [2:0] driveSelect_reg;
    reg completionErrorMask_reg;
    reg attentionMask_reg;
    reg [WC_W-1:0] wordCountLoad_reg;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg jobDone_reg;
    reg [7:0] unitAttention_reg;
    reg writeProtErr_reg;
    reg driveErr_reg;
    reg wordCountOverflow_reg;
    reg formatStatus_reg;
    reg normalStatus_reg;
    reg lockStatus_reg;
    reg selected_unit_lockout_flag_reg;
    reg wordPending_reg;
    wire lockHit;
    wire lastWord;
    wire [WC_W-1:0] wordsLeft;
    wire attentionFlag;
    wire errorFlag;
    wire summaryDiskFlag;
    wire goWrite;
    wire isWriteFn;
    wire writeBlocked;
    wire wordTaken;
    wire launchOk;
    wire finishXfer;
    wire [DATA_W-1:0] statusWord;

    // Decode a register select for a write
    function wrSel;
        input [3:0] addr;
        input [3:0] off;
        input we;
        begin
            wrSel = we && (addr == off);
        end
    endfunction

    // Write-class functions need write protection checks
    function isWrite;
        input [2:0] fn;
        begin
            isWrite = (fn == `DPC_FN_WRITE) || (fn == `DPC_FN_WRALL) ||
                (fn == `DPC_FN_FORMAT);
        end
    endfunction

    dpc_lockout_cmp #(
        .CYL_W(8)
    ) uLock (
        .lockEnable(lockoutEnable),
        .driveSelect(driveSelect_reg),
        .cylinderTarget(cylinderTarget_reg),
        .lockoutUnit(lockoutUnit),
        .lockoutCylinder(lockoutCylinder),
        .lockHit(lockHit)
    );

    assign wordTaken = wordPending_reg && memoryBreakGrant;

    dpc_word_counter #(
        .WC_W(WC_W)
    ) uCount (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .load(launchOk),
        .loadValue(wordCountLoad_reg),
        .step(wordTaken),
        .remaining_reg(wordsLeft),
        .lastWord(lastWord)
    );

    // Flag aggregation
    assign attentionFlag = |unitAttention_reg;
    assign errorFlag = writeProtErr_reg | driveErr_reg;
    assign summaryDiskFlag = jobDone_reg | attentionFlag | errorFlag;
    assign goWrite = wrSel(regAddr, `DPC_OFF_CTRL, regWrite) &&
        regWdata[`DPC_CTRL_GO];
    assign isWriteFn = isWrite(functionCode_reg);
    // Read-only unit or locked cylinder refuses the write
    assign writeBlocked = isWriteFn && (unitReadOnly || lockHit);
    assign launchOk = goWrite && (state_reg == `DPC_S_IDLE) && !writeBlocked;
    assign finishXfer = lastWord || wordsLeft == {WC_W{1'b0}};

    // Sequencer next state; a start while busy is ignored
    always @* begin
        state_next = state_reg;
        case (state_reg)
            `DPC_S_IDLE: begin
                if (launchOk) begin
                    state_next = `DPC_S_SETUP;
                end
            end
            `DPC_S_SETUP: begin
                state_next = `DPC_S_XFER;
            end
            `DPC_S_XFER: begin
                if (driveFault) begin
                    state_next = `DPC_S_DONE;
                end else if (finishXfer) begin
                    state_next = `DPC_S_DONE;
                end
            end
            `DPC_S_DONE: begin
                state_next = `DPC_S_IDLE;
            end
            default: begin
                state_next = `DPC_S_IDLE;
            end
        endcase
    end

    // Software-loaded registers
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cylinderTarget_reg <= 8'h00;
            headTarget_reg <= 5'h00;
            sectorTarget_reg <= 4'h0;
            functionCode_reg <= 3'h0;
            driveSelect_reg <= 3'h0;
            completionErrorMask_reg <= 1'b0;
            attentionMask_reg <= 1'b0;
            wordCountLoad_reg <= {WC_W{1'b0}};
        end else begin
            if (wrSel(regAddr, `DPC_OFF_CYL, regWrite)) begin
                cylinderTarget_reg <= regWdata[7:0];
            end
            if (wrSel(regAddr, `DPC_OFF_HEAD, regWrite)) begin
                headTarget_reg <= regWdata[4:0];
            end
            if (wrSel(regAddr, `DPC_OFF_SECT, regWrite)) begin
                sectorTarget_reg <= regWdata[3:0];
            end
            if (wrSel(regAddr, `DPC_OFF_FUNC, regWrite)) begin
                functionCode_reg <= regWdata[2:0];
            end
            if (wrSel(regAddr, `DPC_OFF_UNIT, regWrite)) begin
                driveSelect_reg <= regWdata[2:0];
            end
            if (wrSel(regAddr, `DPC_OFF_CTRL, regWrite)) begin
                completionErrorMask_reg <= regWdata[`DPC_CTRL_CEMASK];
                attentionMask_reg <= regWdata[`DPC_CTRL_ATMASK];
            end
            if (wrSel(regAddr, `DPC_OFF_WCNT, regWrite)) begin
                wordCountLoad_reg <= regWdata[WC_W-1:0];
            end
        end
    end

    // Sequencer, transfer handshake and drive-facing outputs
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= `DPC_S_IDLE;
            busy_reg <= 1'b0;
            wordPending_reg <= 1'b0;
            memoryBreakRequest_reg <= 1'b0;
            writeRequest_reg <= 1'b0;
            activeFunction_reg <= 3'h0;
            activeUnit_reg <= 3'h0;
        end else begin
            state_reg <= state_next;
            busy_reg <= (state_next != `DPC_S_IDLE);
            if (launchOk) begin
                activeFunction_reg <= functionCode_reg;
                activeUnit_reg <= driveSelect_reg;
            end
            // Write request only for permitted write functions
            writeRequest_reg <= (state_next == `DPC_S_XFER) &&
                isWrite(activeFunction_reg);
            // Each drive word strobe asks for one memory cycle
            if (state_reg != `DPC_S_XFER || state_next != `DPC_S_XFER) begin
                wordPending_reg <= 1'b0;
            end else if (driveWordStrobe) begin
                wordPending_reg <= 1'b1;
            end else if (memoryBreakGrant) begin
                wordPending_reg <= 1'b0;
            end
            memoryBreakRequest_reg <= (state_next == `DPC_S_XFER) &&
                ((wordPending_reg && !memoryBreakGrant) ||
                driveWordStrobe);
        end
    end

    // Sticky status flags; hardware set beats a software clear
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            jobDone_reg <= 1'b0;
            unitAttention_reg <= 8'h00;
            writeProtErr_reg <= 1'b0;
            driveErr_reg <= 1'b0;
            wordCountOverflow_reg <= 1'b0;
        end else begin
            if (state_reg == `DPC_S_DONE) begin
                jobDone_reg <= 1'b1;
            end else if (goWrite && writeBlocked &&
                    state_reg == `DPC_S_IDLE) begin
                jobDone_reg <= 1'b1;
            end else if (launchOk) begin
                jobDone_reg <= 1'b0;
            end
            // Writing ones to the attention register clears those units
            if (wrSel(regAddr, `DPC_OFF_ATTN, regWrite)) begin
                unitAttention_reg <= seekComplete |
                    (unitAttention_reg & ~regWdata[7:0]);
            end else begin
                unitAttention_reg <= unitAttention_reg | seekComplete;
            end
            if (goWrite && writeBlocked && state_reg == `DPC_S_IDLE) begin
                writeProtErr_reg <= 1'b1;
            end else if (wrSel(regAddr, `DPC_OFF_CTRL, regWrite) &&
                    regWdata[`DPC_CTRL_CLRERR]) begin
                writeProtErr_reg <= 1'b0;
            end
            if (state_reg == `DPC_S_XFER && driveFault) begin
                driveErr_reg <= 1'b1;
            end else if (wrSel(regAddr, `DPC_OFF_CTRL, regWrite) &&
                    regWdata[`DPC_CTRL_CLRERR]) begin
                driveErr_reg <= 1'b0;
            end
            if (lastWord) begin
                wordCountOverflow_reg <= 1'b1;
            end else if (launchOk) begin
                wordCountOverflow_reg <= 1'b0;
            end
        end
    end

    // Switch inputs copied into status; lockout shown as it stands
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            formatStatus_reg <= 1'b0;
            normalStatus_reg <= 1'b0;
            lockStatus_reg <= 1'b0;
            selected_unit_lockout_flag_reg <= 1'b0;
            writeAllMode_reg <= 1'b0;
        end else begin
            formatStatus_reg <= formatSwitch;
            normalStatus_reg <= !formatSwitch;
            lockStatus_reg <= lockoutEnable;
            selected_unit_lockout_flag_reg <= lockHit;
            writeAllMode_reg <= formatSwitch;
        end
    end

    // Masked flags drive both interrupt ports alike
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            programInterrupt_reg <= 1'b0;
            priorityInterrupt_reg <= 1'b0;
        end else begin
            programInterrupt_reg <=
                (!completionErrorMask_reg && (jobDone_reg || errorFlag)) ||
                (!attentionMask_reg && attentionFlag);
            priorityInterrupt_reg <=
                (!completionErrorMask_reg && (jobDone_reg || errorFlag)) ||
                (!attentionMask_reg && attentionFlag);
        end
    end

    // Status word assembly
    assign statusWord = {{(DATA_W-13){1'b0}}, driveErr_reg,
        writeProtErr_reg, selected_unit_lockout_flag_reg, lockStatus_reg, normalStatus_reg,
        formatStatus_reg, wordCountOverflow_reg, memoryBreakRequest_reg,
        summaryDiskFlag, errorFlag, attentionFlag, jobDone_reg, busy_reg};

    // Read data valid the cycle after the strobe; unmapped reads zero
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            regRdata_reg <= {DATA_W{1'b0}};
        end else if (regRead) begin
            case (regAddr)
                `DPC_OFF_CYL: regRdata_reg <= {{(DATA_W-8){1'b0}},
                    cylinderTarget_reg};
                `DPC_OFF_HEAD: regRdata_reg <= {{(DATA_W-5){1'b0}},
                    headTarget_reg};
                `DPC_OFF_SECT: regRdata_reg <= {{(DATA_W-4){1'b0}},
                    sectorTarget_reg};
                `DPC_OFF_FUNC: regRdata_reg <= {{(DATA_W-3){1'b0}},
                    functionCode_reg};
                `DPC_OFF_UNIT: regRdata_reg <= {{(DATA_W-3){1'b0}},
                    driveSelect_reg};
                `DPC_OFF_CTRL: regRdata_reg <= {{(DATA_W-3){1'b0}},
                    attentionMask_reg, completionErrorMask_reg, 1'b0};
                `DPC_OFF_STAT: regRdata_reg <= statusWord;
                `DPC_OFF_ATTN: regRdata_reg <= {{(DATA_W-8){1'b0}},
                    unitAttention_reg};
                `DPC_OFF_WCNT: regRdata_reg <= {{(DATA_W-WC_W){1'b0}},
                    wordsLeft};
                `DPC_OFF_SW: regRdata_reg <= {{(DATA_W-7){1'b0}},
                    lockoutCylinder, lockoutUnit, lockoutEnable};
                default: regRdata_reg <= {DATA_W{1'b0}};
            endcase
        end else begin
            regRdata_reg <= {DATA_W{1'b0}};
        end
    end
endmodule

// [dpc_disk_control_monitor.sv]
// Port-level assertions for the disk pack controller
`timescale 1ns/1ps
`include "dpc_consts.vh"
module dpc_disk_control_monitor #(
    parameter WC_W = 16,
    parameter DATA_W = 18
) (
    input wire sys_clk,
    input wire nrst,
    input wire [3:0] regAddr,
    input wire [DATA_W-1:0] regWdata,
    input wire regWrite,
    input wire regRead,
    input wire [DATA_W-1:0] regRdata_reg,
    input wire formatSwitch,
    input wire lockoutEnable,
    input wire [2:0] lockoutUnit,
    input wire [2:0] lockoutCylinder,
    input wire [7:0] seekComplete,
    input wire unitReadOnly,
    input wire driveFault,
    input wire memoryBreakGrant,
    input wire driveWordStrobe,
    input wire memoryBreakRequest_reg,
    input wire writeRequest_reg,
    input wire writeAllMode_reg,
    input wire programInterrupt_reg,
    input wire priorityInterrupt_reg,
    input wire busy_reg,
    input wire [2:0] activeFunction_reg,
    input wire [2:0] activeUnit_reg
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // Setup, transfer and done each hold busy for at least one cycle
    sequence s_launch;
        $rose(busy_reg);
    endsequence
    sequence s_busyRun;
        busy_reg [*3];
    endsequence
    chk_busy_cause: assert property (s_launch |-> $past(regWrite)
        && $past(regAddr) == `DPC_OFF_CTRL && $past(regWdata[0]))
        else $error("busy rose without a start write");
    chk_busy_span: assert property (s_launch |-> s_busyRun)
        else $error("busy too short after launch");
    chk_wreq_busy: assert property (writeRequest_reg |-> busy_reg)
        else $error("write request while idle");
    chk_wreq_setup: assert property ($rose(writeRequest_reg) |->
        $past(busy_reg)) else $error("write request skipped setup");
    chk_wreq_fn: assert property (writeRequest_reg |->
        activeFunction_reg inside {`DPC_FN_WRITE, `DPC_FN_WRALL,
        `DPC_FN_FORMAT}) else $error("write request for a read function");
    chk_irq_pair: assert property (programInterrupt_reg ==
        priorityInterrupt_reg) else $error("interrupt ports differ");
    chk_fmt_copy: assert property (1'b1 |=>
        writeAllMode_reg == $past(formatSwitch))
        else $error("write-all mode does not follow the switch");
    chk_brk_cause: assert property ($rose(memoryBreakRequest_reg) |->
        $past(driveWordStrobe)) else $error("break request without a word");
    chk_brk_hold: assert property (memoryBreakRequest_reg
        && !memoryBreakGrant && !driveFault |=> memoryBreakRequest_reg)
        else $error("break request dropped before grant");
    chk_rdata_quiet: assert property (regRdata_reg != 0 |->
        $past(regRead)) else $error("read data outside read cycle");
endmodule
bind dpc_disk_control dpc_disk_control_monitor
    #(.WC_W(WC_W), .DATA_W(DATA_W)) mon (.*);

// [dpc_drive_model.sv]
// Drive unit and memory break partner for the controller
`timescale 1ns/1ps
module dpc_drive_model (
    input wire sys_clk,
    input wire nrst,
    input wire xferActive,
    input wire memoryBreakRequest,
    input wire [3:0] waitCycles,
    output reg memoryBreakGrant,
    output reg driveWordStrobe
);
    reg [3:0] cnt;
    reg [2:0] gap;
    // Grant after a chosen latency; the gap keeps a grant or word from
    // repeating while the controller's registered request catches up
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 4'h0;
            gap <= 3'h0;
            memoryBreakGrant <= 1'b0;
            driveWordStrobe <= 1'b0;
        end else begin
            memoryBreakGrant <= 1'b0;
            driveWordStrobe <= 1'b0;
            if (gap != 3'h0) gap <= gap - 3'h1;
            if (memoryBreakRequest && !memoryBreakGrant && gap == 3'h0) begin
                if (cnt >= waitCycles) begin
                    memoryBreakGrant <= 1'b1;
                    cnt <= 4'h0;
                    gap <= 3'h4;
                end else begin
                    cnt <= cnt + 4'h1;
                end
            end else if (xferActive && !memoryBreakRequest && gap == 3'h0) begin
                driveWordStrobe <= 1'b1;
                gap <= 3'h3;
            end
        end
    end
endmodule

// [dpc_disk_control_tb.sv]
// Self-checking bench for the disk pack controller
`timescale 1ns/1ps
`include "dpc_consts.vh"
module dpc_disk_control_tb;
    logic sys_clk, nrst, regWrite, regRead, formatSwitch, lockoutEnable;
    logic unitReadOnly, driveFault, wrSeen;
    logic [3:0] regAddr, waitCycles;
    logic [17:0] regWdata, rd, v;
    logic [2:0] lockoutUnit, lockoutCylinder, fn;
    logic [7:0] seekComplete, cyl;
    wire [17:0] regRdata_reg;
    wire memoryBreakGrant, driveWordStrobe, memoryBreakRequest_reg;
    wire writeRequest_reg, writeAllMode_reg, programInterrupt_reg;
    wire priorityInterrupt_reg, busy_reg;
    wire [2:0] activeFunction_reg, activeUnit_reg;
    int errTotal, nTests, i, u;
    logic [17:0] wMask [0:4] = '{18'hFF, 18'h1F, 18'hF, 18'h7, 18'h7};

    dpc_disk_control uut (.*);
    dpc_drive_model partner (.sys_clk(sys_clk), .nrst(nrst),
        .xferActive(busy_reg), .memoryBreakRequest(memoryBreakRequest_reg),
        .waitCycles(waitCycles), .memoryBreakGrant(memoryBreakGrant),
        .driveWordStrobe(driveWordStrobe));

    always #12.5 sys_clk = ~sys_clk;
    // Remember any write request since the last control write
    always @(posedge sys_clk) wrSeen <= writeRequest_reg === 1'b1 ||
        (wrSeen && !(regWrite && regAddr == `DPC_OFF_CTRL));

    function automatic logic irqExp(input logic dn, er, at, cem, atm);
        return (!cem && (dn || er)) || (!atm && at);
    endfunction
    task automatic cmpVal(input string nm, input [17:0] ex, input [17:0] got);
        nTests++;
        if (got !== ex) begin
            errTotal++;
            $display("Error %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic cmpBit(input string nm, input logic ex, input logic got);
        nTests++;
        if (got !== ex) begin
            errTotal++;
            $display("Error %s expected %b seen %b", nm, ex, got);
        end
    endtask
    task automatic regWr(input [3:0] a, input [17:0] d);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
        #1;
    endtask
    // Read data is only valid in the cycle after the strobe
    task automatic regRd(input [3:0] a, output [17:0] d);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1 d = regRdata_reg;
    endtask
    task automatic waitIdle;
        int n;
        n = 0;
        while (busy_reg !== 1'b0 && n < 2000) begin
            @(posedge sys_clk);
            #1 n++;
        end
        cmpBit("idle", 1'b0, busy_reg);
    endtask
    task automatic settle;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic completeRun;
        $display("Comparisons %0d mismatches %0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Watchdog sized well beyond the expected run length
    initial begin
        #2000000;
        errTotal++;
        completeRun;
    end

    initial begin
        {sys_clk, nrst, regWrite, regRead, formatSwitch, lockoutEnable} = 0;
        {unitReadOnly, driveFault, regAddr, waitCycles} = 0;
        {regWdata, lockoutUnit, lockoutCylinder, seekComplete} = 0;
        errTotal = 0;
        nTests = 0;
        void'($urandom(59));
        repeat (10) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        #1;
        // Target registers keep only their own width
        for (i = 0; i < 5; i++) begin
            v = $urandom;
            regWr(i[3:0], v);
            regRd(i[3:0], rd);
            cmpVal("target reg", v & wMask[i], rd);
        end
        regWr(4'hF, 18'h3FFFF);
        regRd(4'hF, rd);
        cmpVal("unmapped", 18'h0, rd);
        // Switch positions reach the status bits
        for (i = 0; i < 4; i++) begin
            formatSwitch <= i[0];
            lockoutEnable <= i[1];
            lockoutUnit <= $urandom;
            lockoutCylinder <= $urandom;
            settle;
            regRd(`DPC_OFF_STAT, rd);
            cmpBit("format", i[0], rd[`DPC_ST_FMT]);
            cmpBit("normal", !i[0], rd[`DPC_ST_NORMAL_STATUS]);
            cmpBit("lockout", i[1], rd[`DPC_ST_LOCK]);
            regRd(`DPC_OFF_SW, rd);
            cmpVal("switches", {11'h0, lockoutCylinder, lockoutUnit,
                lockoutEnable}, rd);
        end
        // Lockout compare at the inclusive boundary and beside it
        lockoutUnit <= 3'h3;
        lockoutCylinder <= 3'h6;
        for (i = 0; i < 8; i++) begin
            lockoutEnable <= (i != 7);
            v = (i < 4) ? 18'h3 : $urandom % 8;
            cyl = (i == 0) ? 8'h06 : (i == 1) ? 8'h07 : $urandom % 12;
            regWr(`DPC_OFF_UNIT, v);
            regWr(`DPC_OFF_CYL, {10'h0, cyl});
            settle;
            regRd(`DPC_OFF_STAT, rd);
            cmpBit("unit lockout", i != 7 && v == 18'h3 && cyl <= 8'h06,
                rd[`DPC_ST_SELECTED_UNIT_LOCKOUT_FLAG]);
        end
        // Write functions on protected places are refused and flagged
        for (i = 0; i < 3; i++) begin
            lockoutEnable <= (i != 1);
            unitReadOnly <= (i == 1);
            regWr(`DPC_OFF_UNIT, 18'h3);
            regWr(`DPC_OFF_CYL, 18'h6);
            regWr(`DPC_OFF_FUNC, (i == 0) ? 18'h1 : (i == 1) ? 18'h3 : 18'h5);
            regWr(`DPC_OFF_CTRL, 18'h1);
            cmpBit("busy", 1'b0, busy_reg);
            regRd(`DPC_OFF_STAT, rd);
            cmpBit("wp error", 1'b1, rd[`DPC_ST_WPERR]);
            cmpBit("done", 1'b1, rd[`DPC_ST_DONE]);
            cmpBit("error", 1'b1, rd[`DPC_ST_ERR]);
            regWr(`DPC_OFF_CTRL, 18'h8);
            regRd(`DPC_OFF_STAT, rd);
            cmpBit("error", 1'b0, rd[`DPC_ST_ERR]);
        end
        lockoutEnable <= 1'b0;
        unitReadOnly <= 1'b0;
        // Every function code, with word counts and grant delays varied
        for (i = 0; i < 8; i++) begin
            fn = i;
            waitCycles <= $urandom % 6;
            regWr(`DPC_OFF_WCNT, i);
            regWr(`DPC_OFF_FUNC, {15'h0, fn});
            regWr(`DPC_OFF_CTRL, 18'h1);
            cmpBit("busy", 1'b1, busy_reg);
            cmpVal("active fn", {15'h0, fn}, {15'h0, activeFunction_reg});
            cmpVal("active unit", 18'h3, {15'h0, activeUnit_reg});
            waitIdle;
            regRd(`DPC_OFF_STAT, rd);
            cmpBit("done", 1'b1, rd[`DPC_ST_DONE]);
            if (i > 0) cmpBit("wc ovfl", 1'b1, rd[`DPC_ST_WCOV]);
            cmpBit("write req", fn == 1 || fn == 3 || fn == 5, wrSeen);
            regRd(`DPC_OFF_WCNT, rd);
            cmpVal("remaining", 18'h0, rd);
        end
        // Seek completion and every mask combination
        u = $urandom % 8;
        seekComplete <= 8'h01 << u;
        @(posedge sys_clk);
        seekComplete <= 8'h00;
        regRd(`DPC_OFF_ATTN, rd);
        cmpVal("unit attn", 18'h1 << u, rd);
        for (i = 0; i < 4; i++) begin
            regWr(`DPC_OFF_CTRL, {15'h0, i[1:0], 1'b0});
            settle;
            cmpBit("irq", irqExp(1, 0, 1, i[0], i[1]),
                programInterrupt_reg);
            regRd(`DPC_OFF_STAT, rd);
            cmpBit("summary", 1'b1, rd[`DPC_ST_DISK]);
        end
        regWr(`DPC_OFF_ATTN, 18'h1 << u);
        regWr(`DPC_OFF_CTRL, 18'h2);
        settle;
        cmpBit("irq", 1'b0, priorityInterrupt_reg);
        // A drive fault ends a transfer early with an error
        waitCycles <= 4'hF;
        driveFault <= 1'b1;
        regWr(`DPC_OFF_WCNT, 18'h5);
        regWr(`DPC_OFF_CTRL, 18'h1);
        waitIdle;
        driveFault <= 1'b0;
        regRd(`DPC_OFF_STAT, rd);
        cmpBit("error", 1'b1, rd[`DPC_ST_ERR]);
        cmpBit("drive err", 1'b1, rd[`DPC_ST_DRVERR]);
        settle;
        cmpBit("irq", 1'b1, programInterrupt_reg);
        completeRun;
    end
endmodule
